// file: rtl/dscs_top.sv
// Speed select: registers, glitch-free mode switch, core phases and peripheral strobes
`timescale 1ns/1ns
`include "dscs_regs.svh"
module dscs_top
  import dscs_pkg::*;
#(
  parameter int PERIPH_N = 8
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          securityDoubleSpeed,
  input  wire logic [1:0]    uartMode,
  input  dscs_apb_req_s      apbReq,
  output dscs_apb_rsp_s      apbRsp,
  output logic               halfRateClk,
  output logic               doubleSpeedActive,
  output dscs_phase_e        corePhase,
  output logic               machineCycleEnd,
  output logic [PERIPH_N-1:0] periphTick
);
  localparam int UART_IDX = `DSCS_UART_BIT - 1;

  // Software visible control
  logic                doubleSpeedSelect;
  logic [6:0]          periphSpeedSel;
  logic                serialPeriphSpeedSel;
  logic                next_doubleSpeedSelect;
  logic [6:0]          next_periphSpeedSel;
  logic                next_serialPeriphSpeedSel;

  // Applied state
  logic                halfPhase;
  logic                next_halfPhase;
  logic                next_doubleSpeedActive;
  logic [PERIPH_N-1:0] appliedSel;
  logic [PERIPH_N-1:0] next_appliedSel;
  logic [PERIPH_N-1:0] fastRate;
  logic                halfRise;

  // Core phase generator
  dscs_phase_e         next_corePhase;
  logic                next_machineCycleEnd;
  logic                phaseStep;

  // Bus
  logic [9:0]          regIndex;
  logic                hitCtrl0;
  logic                hitCtrl1;
  logic                hitStatus;
  logic                mapped;
  logic                accept;
  logic                pready;
  logic                pslverr;
  logic [31:0]         prdata;
  logic [31:0]         next_prdata;

  assign regIndex  = apbReq.paddr[11:2];
  assign hitCtrl0  = apbReq.paddr[1:0] == 2'h0 && regIndex == {2'h0, `DSCS_CTRL0_INDEX};
  assign hitCtrl1  = apbReq.paddr[1:0] == 2'h0 && regIndex == {2'h0, `DSCS_CTRL1_INDEX};
  assign hitStatus = apbReq.paddr[1:0] == 2'h0 && regIndex == {2'h0, `DSCS_STATUS_INDEX};
  assign mapped    = hitCtrl0 || hitCtrl1 || hitStatus;

  dscs_apb_port u_port (
    .clk     (clk),
    .reset   (reset),
    .req     (apbReq),
    .mapped  (mapped),
    .accept  (accept),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // Register writes and read data
  always_comb begin
    next_doubleSpeedSelect    = doubleSpeedSelect;
    next_periphSpeedSel       = periphSpeedSel;
    next_serialPeriphSpeedSel = serialPeriphSpeedSel;
    next_prdata               = prdata;
    if (accept && apbReq.pwrite && hitCtrl0) begin
      next_doubleSpeedSelect = apbReq.pwdata[`DSCS_DOUBLE_BIT];
      next_periphSpeedSel    = apbReq.pwdata[`DSCS_TWI_BIT:`DSCS_TIMER0_BIT];
    end
    if (accept && apbReq.pwrite && hitCtrl1) begin
      next_serialPeriphSpeedSel = apbReq.pwdata[`DSCS_SPI_BIT];
    end
    if (apbReq.psel && apbReq.penable && !pready && !apbReq.pwrite) begin
      next_prdata = 32'h0;
      if (hitCtrl0) begin
        next_prdata[7:0] = {periphSpeedSel, doubleSpeedSelect};
      end else if (hitCtrl1) begin
        next_prdata[0] = serialPeriphSpeedSel;
      end else if (hitStatus) begin
        next_prdata[0] = doubleSpeedActive;
        next_prdata[1] = halfPhase;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      doubleSpeedSelect    <= securityDoubleSpeed;
      periphSpeedSel       <= `DSCS_CTRL0_RESET;
      serialPeriphSpeedSel <= `DSCS_CTRL1_RESET;
      prdata               <= 32'h0;
    end else begin
      doubleSpeedSelect    <= next_doubleSpeedSelect;
      periphSpeedSel       <= next_periphSpeedSel;
      serialPeriphSpeedSel <= next_serialPeriphSpeedSel;
      prdata               <= next_prdata;
    end
  end

  // Half-rate crystal clock and mode switch on its rising edge
  assign halfRise = !halfPhase;

  always_comb begin
    next_halfPhase         = !halfPhase;
    next_doubleSpeedActive = doubleSpeedActive;
    next_appliedSel        = appliedSel;
    if (halfRise) begin
      next_doubleSpeedActive = doubleSpeedSelect;
      next_appliedSel        = {serialPeriphSpeedSel, periphSpeedSel};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      halfPhase         <= 1'b0;
      halfRateClk       <= 1'b0;
      doubleSpeedActive <= 1'b0;
      appliedSel        <= '0;
    end else begin
      halfPhase         <= next_halfPhase;
      halfRateClk       <= next_halfPhase;
      doubleSpeedActive <= next_doubleSpeedActive;
      appliedSel        <= next_appliedSel;
    end
  end

  // Core phases: each lasts one crystal period in double speed, two otherwise
  assign phaseStep = doubleSpeedActive || halfPhase;

  always_comb begin
    next_corePhase       = corePhase;
    next_machineCycleEnd = 1'b0;
    if (phaseStep) begin
      unique case (corePhase)
        PHASE1: next_corePhase = PHASE2;
        PHASE2: next_corePhase = PHASE3;
        PHASE3: next_corePhase = PHASE4;
        PHASE4: next_corePhase = PHASE5;
        PHASE5: next_corePhase = PHASE6;
        PHASE6: begin
          next_corePhase       = PHASE1;
          next_machineCycleEnd = 1'b1;
        end
        default: next_corePhase = PHASE1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      corePhase       <= PHASE1;
      machineCycleEnd <= 1'b0;
    end else begin
      corePhase       <= next_corePhase;
      machineCycleEnd <= next_machineCycleEnd;
    end
  end

  // Peripheral strobes: fast only in double speed with the bit clear, or in double speed for the UART in modes 1 and 3
  for (genvar i = 0; i < PERIPH_N; i++) begin : g_periph
    if (i == UART_IDX) begin : g_uart
      // Modes 1 and 3 follow the core rate
      assign fastRate[i] = doubleSpeedActive
                           && (uartMode[0] || !appliedSel[i]);
    end else begin : g_plain
      assign fastRate[i] = doubleSpeedActive && !appliedSel[i];
    end
    dscs_period_counter u_cnt (
      .clk      (clk),
      .reset    (reset),
      .fastRate (fastRate[i]),
      .tick     (periphTick[i])
    );
  end

  assign apbRsp.prdata  = prdata;
  assign apbRsp.pready  = pready;
  assign apbRsp.pslverr = pslverr;
endmodule

// file: rtl/dscs_regs.svh
// Register map, field positions, reset values and timing counts of the speed select block
`ifndef DSCS_REGS_SVH
`define DSCS_REGS_SVH

// Register indexes; byte address is four times the index
`define DSCS_CTRL0_INDEX   8'h8f
`define DSCS_CTRL1_INDEX   8'haf
`define DSCS_STATUS_INDEX  8'h90
`define DSCS_ADDR_W        12

// Control register 0 fields
`define DSCS_DOUBLE_BIT    0
`define DSCS_TIMER0_BIT    1
`define DSCS_TIMER1_BIT    2
`define DSCS_TIMER2_BIT    3
`define DSCS_UART_BIT      4
`define DSCS_PCA_BIT       5
`define DSCS_WDOG_BIT      6
`define DSCS_TWI_BIT       7
// Control register 1 field
`define DSCS_SPI_BIT       0

// Reset values; global bit comes from the security byte
`define DSCS_CTRL0_RESET   7'h00
`define DSCS_CTRL1_RESET   1'h0

// Timing: oscillator period in ns, cycle lengths in oscillator periods
`define DSCS_OSC_PERIOD_NS 100
`define DSCS_STD_PERIODS   12
`define DSCS_FAST_PERIODS  6
`define DSCS_PHASES        6

`endif

// file: rtl/dscs_pkg.sv
// Types shared by the speed select block
package dscs_pkg;

  typedef enum logic [2:0] {
    PHASE1,
    PHASE2,
    PHASE3,
    PHASE4,
    PHASE5,
    PHASE6
  } dscs_phase_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dscs_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dscs_apb_rsp_s;

endpackage

// file: rtl/dscs_period_counter.sv
// Peripheral cycle strobe with six or twelve oscillator periods per cycle
`timescale 1ns/1ns
`include "dscs_regs.svh"
module dscs_period_counter
  import dscs_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic fastRate,
  output logic      tick
);
  localparam logic [CNT_W-1:0] STD_LAST  = CNT_W'(`DSCS_STD_PERIODS - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(`DSCS_FAST_PERIODS - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_tick;

  always_comb begin
    next_tick  = 1'b0;
    next_count = count + CNT_W'(1);
    if (count == STD_LAST || (fastRate && count == FAST_LAST)) begin
      next_tick  = 1'b1;
      next_count = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule

// file: rtl/dscs_apb_port.sv
// APB handshake: one wait state, registered ready and error
`timescale 1ns/1ns
`include "dscs_regs.svh"
module dscs_apb_port
  import dscs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  dscs_apb_req_s      req,
  input  wire logic          mapped,
  output logic               accept,
  output logic               pready,
  output logic               pslverr
);
  logic next_pready;
  logic next_pslverr;

  // Accept at the edge where the master sees pready high
  assign accept = req.psel && req.penable && pready;

  always_comb begin
    next_pready  = req.psel && req.penable && !pready;
    next_pslverr = next_pready && !mapped;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule

// file: sim/dscs_props.sv
// Checker for the speed select block ports
`timescale 1ns/1ns
module dscs_props
  import dscs_pkg::*;
#(
  parameter int PERIPH_N = 8
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  dscs_apb_req_s            apbReq,
  input  dscs_apb_rsp_s            apbRsp,
  input  wire logic                halfRateClk,
  input  wire logic                doubleSpeedActive,
  input  dscs_phase_e              corePhase,
  input  wire logic                machineCycleEnd,
  input  wire logic [PERIPH_N-1:0] periphTick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_half;
    !$past(reset) |-> halfRateClk != $past(halfRateClk);
  endproperty
  a_half: assert property (p_half) else $error("half rate clock stalled");
  property p_fast;
    machineCycleEnd && doubleSpeedActive ##1 doubleSpeedActive [*6] |-> machineCycleEnd;
  endproperty
  a_fast: assert property (p_fast) else $error("double speed cycle not 6");
  property p_std;
    machineCycleEnd && !doubleSpeedActive ##1 !doubleSpeedActive [*6] |-> !machineCycleEnd;
  endproperty
  a_std: assert property (p_std) else $error("standard cycle too short");
  property p_switch;
    $changed(doubleSpeedActive) |-> $rose(halfRateClk);
  endproperty
  a_switch: assert property (p_switch) else $error("mode changed off half edge");
  property p_tick;
    periphTick[0] && !doubleSpeedActive ##1 !doubleSpeedActive [*6] |-> !periphTick[0];
  endproperty
  a_tick: assert property (p_tick) else $error("peripheral fast in standard");
  property p_wrap;
    machineCycleEnd |-> corePhase == PHASE1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("cycle end off phase one");
  property p_ready;
    apbReq.psel && $rose(apbReq.penable) |=> apbRsp.pready ##1 !apbRsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing wrong");
  property p_err;
    apbRsp.pslverr |-> apbRsp.pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule
bind dscs_top dscs_props #(.PERIPH_N(PERIPH_N)) chk_u (.clk(clk), .reset(reset),
  .apbReq(apbReq), .apbRsp(apbRsp), .halfRateClk(halfRateClk),
  .doubleSpeedActive(doubleSpeedActive), .corePhase(corePhase),
  .machineCycleEnd(machineCycleEnd), .periphTick(periphTick));

// file: sim/dscs_top_test.sv
// Self-checking bench for the speed select block
`timescale 1ns/1ns
`include "dscs_regs.svh"
module dscs_top_test
  import dscs_pkg::*;
;
  localparam logic [11:0] ADR0 = {2'b00, `DSCS_CTRL0_INDEX, 2'b00};
  localparam logic [11:0] ADR1 = {2'b00, `DSCS_CTRL1_INDEX, 2'b00};
  localparam logic [11:0] ADRS = {2'b00, `DSCS_STATUS_INDEX, 2'b00};
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic          securityDoubleSpeed = 1'b1;
  logic [1:0]    uartMode = 2'h0;
  dscs_apb_req_s apbReq = '0;
  dscs_apb_rsp_s apbRsp;
  logic          halfRateClk;
  logic          doubleSpeedActive;
  dscs_phase_e   corePhase;
  logic          machineCycleEnd;
  logic [7:0]    periphTick;
  logic [8:0]    ev;
  logic [31:0]   rd;
  logic          er;
  logic [7:0]    c;
  logic          h;
  int            errors = 0;
  int            comparisons = 0;
  assign ev = {machineCycleEnd, periphTick};
  always #50 clk = ~clk;
  dscs_top #(.PERIPH_N(8)) dut_u (.clk(clk), .reset(reset),
    .securityDoubleSpeed(securityDoubleSpeed), .uartMode(uartMode), .apbReq(apbReq),
    .apbRsp(apbRsp), .halfRateClk(halfRateClk), .doubleSpeedActive(doubleSpeedActive),
    .corePhase(corePhase), .machineCycleEnd(machineCycleEnd), .periphTick(periphTick));
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq <= '0;
    if (apbRsp.pready !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask
  // Second interval between pulses, so a rate change has settled
  task automatic per(input int b, input int e);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (ev[b] !== 1'b1 && n < 30);
    end
    if (ev[b] !== 1'b1) begin
      errors++;
      print_verdict();
    end
    chk("tick period", e, n);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, ADR0, '0);
    chk("ctrl0 reset", 32'h1, rd);
    apb(1'b0, ADR1, '0);
    chk("ctrl1 reset", 32'h0, rd);
    apb(1'b0, ADRS, '0);
    chk("active", 32'h1, {31'h0, rd[0]});
    apb(1'b1, ADR0, 32'hfe);
    apb(1'b0, ADR0, '0);
    chk("ctrl0", 32'hfe, rd);
    chk("active port", 32'h0, {31'h0, doubleSpeedActive});
    @(posedge clk);
    #1;
    h = halfRateClk;
    @(posedge clk);
    #1;
    chk("half rate clock", {31'h0, ~h}, {31'h0, halfRateClk});
    for (int i = 0; i < 9; i++) per(i, 12);
    apb(1'b1, ADR0, 32'h01);
    for (int i = 0; i < 9; i++) per(i, 6);
    chk("active port", 32'h1, {31'h0, doubleSpeedActive});
    per(8, 6);
    chk("phase at cycle end", 32'(PHASE1), 32'(corePhase));
    apb(1'b1, ADR1, 32'h01);
    per(7, 12);
    for (int v = 0; v < 2; v++) begin
      c = v ? 8'hab : 8'h55;
      apb(1'b1, ADR0, {24'h0, c});
      for (int i = 0; i < 7; i++) per(i, c[i+1] ? 12 : 6);
    end
    apb(1'b1, ADR0, 32'h11);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      uartMode <= 2'(m);
      per(3, m[0] ? 6 : 12);
    end
    apb(1'b0, 12'h004, '0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // Second reset with the security bit low; held long enough for the checker
    @(posedge clk);
    securityDoubleSpeed <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, ADR0, '0);
    chk("ctrl0 second reset", 32'h0, rd);
    apb(1'b0, ADR1, '0);
    chk("ctrl1 second reset", 32'h0, rd);
    per(8, 12);
    print_verdict();
  end
endmodule
